// ==== core/current_power_calc_engine.sv ====
// current and power calculation engine with its six-register bank
// assumes: serial front end hands whole 16-bit words plus a write strobe,
// conversion logic delivers shunt and bus words with a valid pulse
`default_nettype none
module current_power_calc_engine
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_ptr_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic shunt_valid_i,
  input wire logic [15:0] shunt_data_i,
  input wire logic bus_valid_i,
  input wire logic [15:0] bus_data_i,
  output logic [15:0] rd_data_o,
  output logic [15:0] config_o,
  output logic [15:0] current_o,
  output logic [15:0] power_o
);
  import pwr_calc_pkg::*;

  // ---------------------------------------------
  // write staging: new contents land after settle
  // ---------------------------------------------
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic pend_q, pend_d;
  logic [7:0] pend_ptr_q, pend_ptr_d;
  logic [15:0] pend_data_q, pend_data_d;
  logic [15:0] config_q, config_d;
  logic [15:0] calib_q, calib_d;
  logic [15:0] shunt_q, shunt_d;
  logic [15:0] bus_q, bus_d;
  logic [15:0] current_q, current_d;
  logic [15:0] power_q, power_d;
  logic [15:0] rd_q, rd_d;
  logic recalc_q, recalc_d;
  logic commit;

  assign commit = pend_q && (settle_q == SETTLE_W'(1));

  always_comb begin
    pend_d = pend_q;
    pend_ptr_d = pend_ptr_q;
    pend_data_d = pend_data_q;
    settle_d = settle_q;
    if (wr_en_i) begin
      // a newer write restarts the settle window
      pend_d = 1'b1;
      pend_ptr_d = reg_ptr_i;
      pend_data_d = wr_data_i;
      settle_d = SETTLE_W'(SETTLE_CYCLES);
    end else if (commit) begin
      pend_d = 1'b0;
      settle_d = '0;
    end else if (pend_q) begin
      settle_d = settle_q - SETTLE_W'(1);
    end
  end

  // ---------------------------------------------
  // register bank
  // ---------------------------------------------
  always_comb begin
    config_d = config_q;
    calib_d = calib_q;
    shunt_d = shunt_valid_i ? shunt_data_i : shunt_q;
    bus_d = bus_valid_i ? bus_data_i : bus_q;
    recalc_d = shunt_valid_i || bus_valid_i;
    if (commit) begin
      unique case (pend_ptr_q)
        PTR_CONFIG: config_d = pend_data_q;
        PTR_CALIB: begin
          calib_d = pend_data_q;
          recalc_d = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------
  // arithmetic
  // ---------------------------------------------
  // signed wide products; the division is truncating toward zero so the
  // sign of the current survives into the power word
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_wide;
  logic signed [15:0] cur_next;
  logic signed [29:0] pwr_prod;
  logic signed [29:0] pwr_wide;
  logic [12:0] bus_count;

  assign bus_count = bus_q[15:BUS_ALIGN_SHIFT];
  assign cur_prod = $signed(shunt_q) * $signed({1'b0, calib_q});
  assign cur_wide = cur_prod / 33'sd4096;
  assign cur_next = cur_wide[15:0];
  // 5000 folds the 4 mV bus unit into a 20x current unit
  assign pwr_prod = cur_next * $signed({1'b0, bus_count});
  assign pwr_wide = pwr_prod / 30'sd5000;

  always_comb begin
    current_d = current_q;
    power_d = power_q;
    if (calib_q == CALIB_RESET) begin
      current_d = RESULT_RESET;
      power_d = RESULT_RESET;
    end else if (recalc_q) begin
      current_d = cur_next;
      power_d = pwr_wide[15:0];
    end
  end

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  always_comb begin
    unique case (reg_ptr_i)
      PTR_CONFIG: rd_d = config_q;
      PTR_SHUNT: rd_d = shunt_q;
      PTR_BUS: rd_d = bus_q;
      PTR_POWER: rd_d = power_q;
      PTR_CURRENT: rd_d = current_q;
      PTR_CALIB: rd_d = calib_q;
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      settle_q <= '0;
      pend_q <= 1'b0;
      pend_ptr_q <= 8'h00;
      pend_data_q <= 16'h0000;
      config_q <= CONFIG_RESET;
      calib_q <= CALIB_RESET;
      shunt_q <= 16'h0000;
      bus_q <= 16'h0000;
      current_q <= RESULT_RESET;
      power_q <= RESULT_RESET;
      rd_q <= 16'h0000;
      recalc_q <= 1'b0;
    end else begin
      settle_q <= settle_d;
      pend_q <= pend_d;
      pend_ptr_q <= pend_ptr_d;
      pend_data_q <= pend_data_d;
      config_q <= config_d;
      calib_q <= calib_d;
      shunt_q <= shunt_d;
      bus_q <= bus_d;
      current_q <= current_d;
      power_q <= power_d;
      rd_q <= rd_d;
      recalc_q <= recalc_d;
    end
  end

  assign rd_data_o = rd_q;
  assign config_o = config_q;
  assign current_o = current_q;
  assign power_o = power_q;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  // helper: cycles since the last write, saturating, and what it carried;
  // a counter instead of a long repetition keeps the settle check cheap
  logic [SETTLE_W-1:0] wr_age_q, wr_age_d;
  logic [7:0] wr_seen_ptr_q, wr_seen_ptr_d;
  logic [15:0] wr_seen_data_q, wr_seen_data_d;

  always_comb begin
    wr_age_d = wr_age_q;
    wr_seen_ptr_d = wr_seen_ptr_q;
    wr_seen_data_d = wr_seen_data_q;
    if (wr_en_i) begin
      wr_age_d = '0;
      wr_seen_ptr_d = reg_ptr_i;
      wr_seen_data_d = wr_data_i;
    end else if (wr_age_q != '1) begin
      wr_age_d = wr_age_q + SETTLE_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_age_q <= '1;
      wr_seen_ptr_q <= 8'h00;
      wr_seen_data_q <= 16'h0000;
    end else begin
      wr_age_q <= wr_age_d;
      wr_seen_ptr_q <= wr_seen_ptr_d;
      wr_seen_data_q <= wr_seen_data_d;
    end
  end

  chk_zero_cal_results: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(calib_q) == 16'h0000
    |-> current_q == 16'h0000 && power_q == 16'h0000)
    else $error("results not zero under zero calibration");

  chk_write_settle: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    wr_en_i && reg_ptr_i == PTR_CALIB ##1 (!wr_en_i) [*8]
    |-> calib_q == $past(calib_q, 8))
    else $error("calibration took effect too early");

  chk_write_lands: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    !wr_en_i && wr_seen_ptr_q == PTR_CALIB
    && wr_age_q == SETTLE_W'(SETTLE_CYCLES - 1)
    |=> calib_q == wr_seen_data_q)
    else $error("calibration did not land after settle");

  chk_current_calc: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    recalc_q && calib_q != 16'h0000
    |=> $signed(current_q) == 16'(($signed($past(shunt_q))
      * $signed({17'h00000, $past(calib_q)})) / 4096))
    else $error("current result wrong");

  // beyond 15 magnitude bits the word wraps, so overflow is left out
  chk_current_sign: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    recalc_q && calib_q != 16'h0000 && $signed(shunt_q) < 0
    && cur_wide < 0 && cur_wide >= -33'sd32768
    |=> current_q[15])
    else $error("negative current lost its sign");

  chk_power_calc: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    recalc_q && calib_q != 16'h0000
    |=> $signed(power_q) == 16'(($signed(current_q)
      * $signed({1'b0, $past(bus_q[15:3])})) / 5000))
    else $error("power result wrong");

  chk_recalc_event: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    shunt_valid_i || bus_valid_i |=> recalc_q)
    else $error("new sample not scheduled");

  chk_read_pointer: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    reg_ptr_i == PTR_CURRENT |=> rd_data_o == $past(current_q))
    else $error("read pointer mismatch");
endmodule // current_power_calc_engine
`default_nettype wire

// ==== core/pwr_calc_pkg.sv ====
// package: register pointers, reset values and scaling constants
// assumes: one 40 MHz clock domain, synchronous active-low reset
`default_nettype none
package pwr_calc_pkg;
  localparam logic [7:0] PTR_CONFIG = 8'h00;
  localparam logic [7:0] PTR_SHUNT = 8'h01;
  localparam logic [7:0] PTR_BUS = 8'h02;
  localparam logic [7:0] PTR_POWER = 8'h03;
  localparam logic [7:0] PTR_CURRENT = 8'h04;
  localparam logic [7:0] PTR_CALIB = 8'h05;
  localparam logic [15:0] CONFIG_RESET = 16'h399F;
  localparam logic [15:0] CALIB_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CURRENT_SHIFT = 12;
  localparam int POWER_DIVISOR = 5000;
  localparam int BUS_ALIGN_SHIFT = 3;
  localparam int POWER_LSB_RATIO = 20;
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 4000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = 8;
endpackage : pwr_calc_pkg
`default_nettype wire

// ==== tb/host_model.sv ====
// host model: drives register pointer and whole-word writes
// assumes: byte pairing already done by the serial front end
`default_nettype none
module host_model (
  input wire logic mclk_i,
  input wire logic [15:0] rd_data_i,
  output var logic [7:0] reg_ptr_o,
  output var logic wr_en_o,
  output var logic [15:0] wr_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_ptr_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 16'h0000;
  end
  // caller leaves the settle gap; the model never queues writes
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    @(posedge mclk_i);
    reg_ptr_o <= ptr;
    wr_en_o <= 1'b1;
    wr_data_o <= data;
    @(posedge mclk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~data; // stale word must not look valid
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
    @(posedge mclk_i);
    reg_ptr_o <= ptr;
    repeat (2) @(posedge mclk_i);
    data = rd_data_i;
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/current_power_calc_engine_tb.sv ====
// testbench: register traffic and conversion samples, self-checking
// assumes: package pointers, reset values and a 160-cycle settle
`default_nettype none
module current_power_calc_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_calc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_ptr;
  logic wr_en, shunt_valid = 1'b0, bus_valid = 1'b0;
  logic [15:0] wr_data, rd_data, cfg, cur, pwr, v;
  logic [15:0] shunt_data = 16'h0000;
  logic [15:0] bus_data = 16'h0000;
  int num_errors = 0;
  int checked = 0;
  always #12.5 mclk_i = ~mclk_i;
  host_model u_host_model (.mclk_i(mclk_i), .rd_data_i(rd_data),
    .reg_ptr_o(reg_ptr), .wr_en_o(wr_en), .wr_data_o(wr_data));
  current_power_calc_engine u_current_power_calc_engine (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_ptr_i(reg_ptr),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .shunt_valid_i(shunt_valid),
    .shunt_data_i(shunt_data), .bus_valid_i(bus_valid),
    .bus_data_i(bus_data), .rd_data_o(rd_data), .config_o(cfg),
    .current_o(cur), .power_o(pwr));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conv(input logic [15:0] s, input logic [15:0] b);
    @(posedge mclk_i);
    shunt_valid <= 1'b1;
    shunt_data <= s;
    bus_valid <= 1'b1;
    bus_data <= b;
    @(posedge mclk_i);
    shunt_valid <= 1'b0;
    bus_valid <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      u_host_model.rd(8'(i), v);
      chk(v, (i == 0) ? CONFIG_RESET : 16'h0000);
    end
    conv(16'h07D0, 16'h5D98);
    chk(cur, 16'h0000);
    chk(pwr, 16'h0000);
    $display("reset and zero calibration done");
    u_host_model.wr(PTR_CALIB, 16'h5000);
    u_host_model.rd(PTR_CALIB, v);
    chk(v, 16'h0000);
    repeat (160) @(posedge mclk_i);
    u_host_model.rd(PTR_CALIB, v);
    chk(v, 16'h5000);
    u_host_model.rd(PTR_CURRENT, v);
    chk(v, 16'h2710);
    u_host_model.rd(PTR_POWER, v);
    chk(v, 16'h1766);
    conv(16'hF830, 16'h5D98);
    chk(cur, 16'hD8F0);
    chk(pwr, 16'hE89A);
    conv(16'h07D0, 16'h9C40);
    chk(pwr, 16'h2710);
    $display("scaling done");
    u_host_model.wr(PTR_CURRENT, 16'h1234);
    repeat (161) @(posedge mclk_i);
    chk(cur, 16'h2710);
    u_host_model.wr(PTR_CONFIG, 16'h019F);
    repeat (161) @(posedge mclk_i);
    chk(cfg, 16'h019F);
    u_host_model.wr(PTR_CALIB, 16'h2800);
    repeat (163) @(posedge mclk_i);
    chk(cur, 16'h1388);
    chk(pwr, 16'h1388);
    u_host_model.wr(PTR_CALIB, 16'h0000);
    repeat (163) @(posedge mclk_i);
    chk(cur, 16'h0000);
    chk(pwr, 16'h0000);
    $display("writes and recalibration done");
    test_done();
  end
endmodule // current_power_calc_engine_tb
`default_nettype wire
